// File: dv/supply_pin_model.sv
`timescale 1ns/1ps
// Board side: reset pin driver and supply monitors, moved on clock edges
module supply_pin_model (
  input wire logic clk_sys,
  input wire logic pin_low,
  input wire logic supply_off,
  input wire logic [2:0] mon_low,
  output logic ext_rst_pin_n = 1'b1,
  output logic supply_above_por = 1'b1,
  output logic [2:0] supply_below_mon = 3'h0
);
  // Pin held low while asked, supply dips, monitor trips
  always @(posedge clk_sys) begin
    ext_rst_pin_n <= ~pin_low;
    supply_above_por <= ~supply_off;
    supply_below_mon <= mon_low;
  end
endmodule : supply_pin_model

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import rst_src_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, nmi_sel = 1'b0, sw_wr = 1'b0, pin_low = 1'b0;
  logic supply_off = 1'b0, cold_wr = 1'b0;
  logic [CAUSE_N-1:0] act;
  logic [7:0] ev = 8'h00;
  logic [2:0] mon_low = 3'h0, mon_en = 3'h7, below;
  logic [15:0] key = 16'h0000;
  logic pin_n, above, irst_n, nmi;
  logic [7:0] reg0, reg1, exp0, exp1;
  int failures, tests_run;
  // Design with short release delays
  reset_source_control #(.VARIANT_B(1'b0), .POR_HOLD(8), .HOLD(8)) u_reset_source_control (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .ext_rst_pin_n(pin_n),
    .supply_above_por(above), .independent_watchdog_event(ev[0]),
    .independent_watchdog_nmi_sel(nmi_sel), .wdt_event(ev[1]),
    .supply_below_mon(below), .mon_reset_en(mon_en), .sram_parity_err(ev[2]),
    .sram_ecc_err(ev[3]), .bus_master_mpu_err(ev[4]), .var_err_a(ev[5]), .var_err_b(ev[6]),
    .deep_standby_wake(ev[7]), .soft_reset_wr(sw_wr), .soft_reset_trigger_reg(key),
    .cold_flag_set_wr(cold_wr), .internal_rst_n(irst_n), .independent_watchdog_nmi(nmi),
    .reset_cause_reg0(reg0), .reset_cause_reg1(reg1), .cause_active(act));
  supply_pin_model u_supply_pin_model (.clk_sys(clk_sys), .pin_low(pin_low),
    .supply_off(supply_off), .mon_low(mon_low), .ext_rst_pin_n(pin_n),
    .supply_above_por(above), .supply_below_mon(below));
  // Clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1
  // One cause: hold it, drop it, watch the stretch and the flag
  task hit(input int k);
    int idx;
    idx = (k < 2) ? C_INDEP_WD + k : (k < 7) ? C_SRAMP + k - 2 : (k == 7) ? C_DSBY : C_LVD0 + k - 8;
    if (k < 8) ev[k] <= 1'b1;
    else mon_low[k-8] <= 1'b1;
    step(6);
    #1;
    chk1(irst_n, 1'b0);
    chk1(act[idx], 1'b1);
    step(1);
    ev <= 8'h00;
    mon_low <= 3'h0;
    if (k < 2) exp1[k] = 1'b1;
    else if (k < 7) exp1[k+1] = 1'b1;
    else if (k == 7) exp0[7] = 1'b1;
    else exp0[k-7] = 1'b1;
    step(3);
    #1;
    chk1(irst_n, 1'b0);
    step(50);
    #1;
    chk1(irst_n, 1'b1);
    chk8(reg0, exp0);
    chk8(reg1, exp1);
    step(1);
  endtask : hit
  task results();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // Watchdog against a hang
  initial begin
    #100000;
    failures++;
    results();
  end
  // Main sequence
  initial begin
    exp0 = 8'h01;
    exp1 = 8'h00;
    step(12);
    rst_n <= 1'b1;
    step(30);
    #1;
    chk8(reg0, 8'h01);
    chk8(reg1, 8'h00);
    chk1(irst_n, 1'b1);
    step(1);
    // Wrong key is ignored
    sw_wr <= 1'b1;
    key <= 16'hA500;
    step(1);
    sw_wr <= 1'b0;
    step(20);
    #1;
    chk1(irst_n, 1'b1);
    chk8(reg1, 8'h00);
    step(1);
    // Watchdog set to interrupt instead of reset
    nmi_sel <= 1'b1;
    ev[0] <= 1'b1;
    step(6);
    #1;
    chk1(nmi, 1'b1);
    chk1(irst_n, 1'b1);
    chk8(reg1, 8'h00);
    step(1);
    // Let the synchronised event drain before leaving interrupt mode
    ev <= 8'h00;
    step(4);
    nmi_sel <= 1'b0;
    mon_en <= 3'h0;
    mon_low <= 3'h7;
    step(6);
    #1;
    chk1(irst_n, 1'b1);
    chk8(reg0, 8'h01);
    step(1);
    // Keep monitors disabled until the tripped levels have drained
    mon_low <= 3'h0;
    step(6);
    mon_en <= 3'h7;
    step(30);
    for (int k = 0; k < 11; k++) hit(k);
    // Software request with the key
    sw_wr <= 1'b1;
    key <= SW_KEY;
    #1;
    chk1(irst_n, 1'b0);
    chk1(act[C_SW], 1'b1);
    step(1);
    sw_wr <= 1'b0;
    exp1[2] = 1'b1;
    step(30);
    #1;
    chk8(reg1, exp1);
    step(1);
    // Pin reset clears the cold bit
    pin_low <= 1'b1;
    step(4);
    #1;
    chk1(irst_n, 1'b0);
    step(1);
    pin_low <= 1'b0;
    exp0[0] = 1'b0;
    step(30);
    #1;
    chk8(reg0, exp0);
    chk8(reg1, exp1);
    step(1);
    // Supply dip: power-on reset reloads flags
    supply_off <= 1'b1;
    step(6);
    #1;
    chk1(irst_n, 1'b0);
    chk8(reg0, 8'h01);
    chk8(reg1, 8'h00);
    step(1);
    supply_off <= 1'b0;
    step(4);
    #1;
    chk1(irst_n, 1'b0);
    step(40);
    #1;
    chk1(irst_n, 1'b1);
    step(1);
    // Cold flag clear strobe
    cold_wr <= 1'b1;
    step(1);
    cold_wr <= 1'b0;
    #1;
    chk8(reg0, 8'h00);
    results();
  end
endmodule : tb_top

// File: src/reset_source_control.sv
`timescale 1ns/1ps
// Collects reset causes, stretches them, keeps cause flags
module reset_source_control
  import rst_src_pkg::*;
#(
  parameter bit VARIANT_B = 1'b0,
  parameter int unsigned POR_HOLD = POR_HOLD_CYC,
  parameter int unsigned HOLD = HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic ext_rst_pin_n,
  input wire logic supply_above_por,
  input wire logic independent_watchdog_event,
  input wire logic independent_watchdog_nmi_sel,
  input wire logic wdt_event,
  input wire logic [2:0] supply_below_mon,
  input wire logic [2:0] mon_reset_en,
  input wire logic sram_parity_err,
  input wire logic sram_ecc_err,
  input wire logic bus_master_mpu_err,
  input wire logic var_err_a,
  input wire logic var_err_b,
  input wire logic deep_standby_wake,
  input wire logic soft_reset_wr,
  input wire logic [15:0] soft_reset_trigger_reg,
  input wire logic cold_flag_set_wr,
  output logic internal_rst_n,
  output logic independent_watchdog_nmi,
  output logic [7:0] reset_cause_reg0,
  output logic [7:0] reset_cause_reg1,
  output logic [CAUSE_N-1:0] cause_active
);
  // Elaboration check on the hold counts
  if (POR_HOLD < 1 || HOLD < 1) begin : g_bad_hold
    $error("Hold counts must be at least 1");
  end
  // Input synchronisers, two stages each
  logic [10:0] sy1_q;
  logic [10:0] sy2_q;
  logic [10:0] raw_in;
  assign raw_in = {var_err_b, var_err_a, bus_master_mpu_err, sram_ecc_err, sram_parity_err,
                   supply_below_mon, wdt_event, independent_watchdog_event, supply_above_por};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sy1_q <= '0;
      sy2_q <= '0;
    end else if (clk_en) begin
      sy1_q <= raw_in;
      sy2_q <= sy1_q;
    end
  end
  logic pin_s1_q;
  logic pin_s2_q;
  // Pin synchroniser resets to the asserted level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else if (clk_en) begin
      pin_s1_q <= ext_rst_pin_n;
      pin_s2_q <= pin_s1_q;
    end
  end
  logic pin_low;
  logic pin_armed_q;
  logic pin_armed_d;
  logic pin_clear;
  logic por_cause;
  logic key_ok;
  logic [2:0] mon_cause;
  assign pin_low = !pin_s2_q;
  // Pin clears the cold flag only once seen released, never from the sync reset value
  assign pin_clear = pin_low && pin_armed_q;
  assign por_cause = !pin_low && !sy2_q[0];
  assign key_ok = soft_reset_wr && (soft_reset_trigger_reg == SW_KEY);
  assign mon_cause = sy2_q[5:3] & mon_reset_en;
  assign independent_watchdog_nmi = sy2_q[1] && independent_watchdog_nmi_sel;
  // Raw cause vector, pin and power-on highest priority for flags
  logic [CAUSE_N-1:0] cause;
  always_comb begin
    cause = '0;
    cause[C_PIN] = pin_low;
    cause[C_POR] = por_cause;
    cause[C_INDEP_WD] = sy2_q[1] && !independent_watchdog_nmi_sel;
    cause[C_WDT] = sy2_q[2];
    cause[C_LVD0 +: 3] = mon_cause;
    cause[C_SRAMP] = sy2_q[6];
    cause[C_SRAME] = sy2_q[7];
    cause[C_BMPU] = sy2_q[8];
    cause[C_VAR0] = sy2_q[9];
    cause[C_VAR1] = sy2_q[10];
    cause[C_DSBY] = deep_standby_wake;
    cause[C_SW] = key_ok;
  end
  assign cause_active = cause;
  // One release timer per cause
  logic [CAUSE_N-1:0] hold;
  genvar gi;
  generate
    for (gi = 0; gi < CAUSE_N; gi++) begin : g_tmr
      localparam int unsigned CY = (gi == C_POR) ? POR_HOLD :
                                   (gi == C_DSBY) ? DSBY_CYC :
                                   (gi == C_PIN) ? 1 : HOLD;
      rst_release_timer #(.CYCLES(CY)) u_tmr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .cause(cause[gi]),
        .hold(hold[gi])
      );
    end
  endgenerate
  // Pin low drops reset at once, without waiting for sync
  logic any_hold;
  assign any_hold = |hold;
  assign internal_rst_n = ext_rst_pin_n && !any_hold;
  // Cause flags: set wins, kept until power-on, except the cold flag, which pin reset or cold_flag_set_wr clears
  logic [7:0] r0_q;
  logic [7:0] r0_d;
  logic [7:0] r1_q;
  logic [7:0] r1_d;
  always_comb begin
    r0_d = r0_q;
    r1_d = r1_q;
    pin_armed_d = pin_armed_q | pin_s2_q;
    if (cold_flag_set_wr) begin
      r0_d[R0_COLD] = 1'b0;
    end
    if (pin_clear) begin
      r0_d[R0_COLD] = 1'b0;
    end
    if (cause[C_POR]) begin
      r0_d = CAUSE0_RST;
      r1_d = CAUSE1_RST;
    end else begin
      r0_d[R0_LVD0 +: 3] = r0_q[R0_LVD0 +: 3] | mon_cause;
      r0_d[R0_DSBY] = r0_q[R0_DSBY] | cause[C_DSBY];
      r1_d[R1_INDEP_WD] = r1_q[R1_INDEP_WD] | cause[C_INDEP_WD];
      r1_d[R1_WDT] = r1_q[R1_WDT] | cause[C_WDT];
      r1_d[R1_SW] = r1_q[R1_SW] | cause[C_SW];
      r1_d[R1_ERR +: 5] = r1_q[R1_ERR +: 5] | cause[C_SRAMP +: 5];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r0_q <= CAUSE0_RST;
      r1_q <= CAUSE1_RST;
      pin_armed_q <= 1'b0;
    end else if (clk_en) begin
      r0_q <= r0_d;
      r1_q <= r1_d;
      pin_armed_q <= pin_armed_d;
    end
  end
  assign reset_cause_reg0 = r0_q;
  assign reset_cause_reg1 = r1_q;

  // Cycles since the power-on cause went away, saturating, for the release check
  localparam int unsigned PGW = $clog2(POR_HOLD + 1);
  logic [PGW-1:0] por_gap_q;
  logic [PGW-1:0] por_gap_d;
  always_comb begin
    por_gap_d = por_gap_q;
    if (por_cause) begin
      por_gap_d = '0;
    end else if (por_gap_q != PGW'(POR_HOLD)) begin
      por_gap_d = por_gap_q + PGW'(1);
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      por_gap_q <= PGW'(POR_HOLD);
    end else if (clk_en) begin
      por_gap_q <= por_gap_d;
    end
  end

  // Assertions
  sequence s_sw_req;
    clk_en && key_ok;
  endsequence
  property p_sw;
    @(posedge clk_sys) disable iff (!rst_n) s_sw_req |=> r1_q[R1_SW] || !clk_en;
  endproperty
  AST_SW_FLAG: assert property (p_sw)
    else $error("Soft reset flag not set");
  AST_PIN_RST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ext_rst_pin_n |-> !internal_rst_n)
    else $error("Pin low without internal reset");
  AST_POR_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    por_cause |-> !internal_rst_n)
    else $error("Power-on cause without reset");
  AST_COLD_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && por_cause |=> r0_q[R0_COLD] || !clk_en)
    else $error("Cold flag not set");
  AST_COLD_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && pin_clear && !por_cause |=> !r0_q[R0_COLD] || !clk_en)
    else $error("Cold flag not cleared by pin");
  AST_POR_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    por_gap_q < PGW'(POR_HOLD) |-> !internal_rst_n)
    else $error("Power-on reset released before hold time");
  AST_MON_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !por_cause |=> ((r0_q[R0_LVD0 +: 3] & $past(mon_cause)) == $past(mon_cause)))
    else $error("Monitor flag not set");
  AST_ERR_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !por_cause |=> ((r1_q[R1_ERR +: 5] & $past(cause[C_SRAMP +: 5])) ==
    $past(cause[C_SRAMP +: 5])))
    else $error("Error cause flag not set");
  AST_INDEP_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && cause[C_INDEP_WD] && !por_cause |=> r1_q[R1_INDEP_WD] || !clk_en)
    else $error("Independent watchdog flag not set");
  AST_FLAG_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !por_cause |=> ((r1_q & $past(r1_q)) == $past(r1_q)) &&
    ((r0_q[7:R0_LVD0] & $past(r0_q[7:R0_LVD0])) == $past(r0_q[7:R0_LVD0])))
    else $error("Cause flag lost without power-on");
  AST_DSBY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && deep_standby_wake && !por_cause |=> r0_q[R0_DSBY] || !clk_en)
    else $error("Deep standby flag not set");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && $fell(cause[C_WDT]) |-> !internal_rst_n)
    else $error("Reset released without delay");
  AST_NMI: assert property (@(posedge clk_sys) disable iff (!rst_n)
    independent_watchdog_nmi |-> !cause[C_INDEP_WD])
    else $error("NMI and reset together");
endmodule : reset_source_control

// File: src/rst_release_timer.sv
`timescale 1ns/1ps
// Holds a request for a release delay after its cause falls
module rst_release_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cause,
  output logic hold
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  // Elaboration check on the delay length
  if (CYCLES < 1) begin : g_bad_cycles
    $error("CYCLES must be at least 1");
  end
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  // Reload while cause stands, count down after
  always_comb begin
    cnt_d = cnt_q;
    if (cause) begin
      cnt_d = W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
    end
  end
  assign hold = cause || (cnt_q != '0);
endmodule : rst_release_timer

// File: src/rst_src_pkg.sv
// Function
// - Low external reset pin aborts processing and holds chip in reset at once
// - Power-on reset generated when pin is high while supply is applied
// - Power-on reset released only after supply above threshold and hold time
// - Supply at or below threshold with pin high re-enters power-on reset
// - Power-on reset sets the cold power-up flag to 1
// - Pin reset clears the cold power-up flag to 0
// - Independent watchdog underflow or refresh error is a reset source
// - Main watchdog underflow or refresh error is a reset source
// - Three voltage monitors each reset when supply drops below their threshold
// - SRAM parity error and SRAM ECC error each raise their own reset
// - Bus-master protection error resets; variant one adds bus-slave and stack errors
// - Variant two replaces those with security and cache parity error resets
// - Interrupt cancelling deep standby raises deep standby reset
// - Fourteen causes including software request all drive one internal reset
// - Writing key 0xA501 requests software reset and sets its flag
// - Independent watchdog underflow resets or raises NMI; reset sets its flag
// - Voltage monitor reset sets the matching channel flag
// - Deep standby reset sets the deep standby flag
package rst_src_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CAUSE_N = 14;
  // Cause indices
  localparam int unsigned C_PIN = 0;
  localparam int unsigned C_POR = 1;
  localparam int unsigned C_INDEP_WD = 2;
  localparam int unsigned C_WDT = 3;
  localparam int unsigned C_LVD0 = 4;
  localparam int unsigned C_SRAMP = 7;
  localparam int unsigned C_SRAME = 8;
  localparam int unsigned C_BMPU = 9;
  localparam int unsigned C_VAR0 = 10;
  localparam int unsigned C_VAR1 = 11;
  localparam int unsigned C_DSBY = 12;
  localparam int unsigned C_SW = 13;
  // Software reset key
  localparam logic [15:0] SW_KEY = 16'hA501;
  // Release delays, in microseconds and cycles
  localparam int unsigned HOLD_US = 320;
  localparam int unsigned HOLD_CYC = HOLD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DSBY_CYC = 35;
  localparam int unsigned POR_HOLD_US = 1000;
  localparam int unsigned POR_HOLD_CYC = POR_HOLD_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0] CAUSE0_RST = 8'h01; // Cold flag set at power-on
  localparam logic [7:0] CAUSE1_RST = 8'h00;
  // Register 0 bit positions
  localparam int unsigned R0_COLD = 0;
  localparam int unsigned R0_LVD0 = 1;
  localparam int unsigned R0_DSBY = 7;
  // Register 1 bit positions
  localparam int unsigned R1_INDEP_WD = 0;
  localparam int unsigned R1_WDT = 1;
  localparam int unsigned R1_SW = 2;
  localparam int unsigned R1_ERR = 3;
endpackage : rst_src_pkg
